/* rtl/fcr_clk_rst.sv */
// Purpose: Clock and reset distribution for a processor subsystem prototype
// Assumes: core_clk is the main oscillator clock; ref_clk_24m is a separate pin clock
// Notes: Clock paths are 1:1; slow clock is a registered fractional divide
`timescale 1ns/10ps
module fcr_clk_rst (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic ref_clk_24m,
  input wire logic cfg_serial_clk,
  input wire logic board_sys_rst_n,
  input wire logic dbg_warm_rst_n,
  input wire logic dbg_test_rst_n,
  input wire logic aux_rst_n,
  input wire logic cfg_block_rst_n,
  input wire logic codec_ctrl_bit,
  output logic slow_clk_32k,
  output logic subsys_slow_clk,
  output fcr_pkg::fcr_ext_clk_type ext_clk_en,
  output fcr_pkg::fcr_subsys_rst_type subsys_rst,
  output logic shield_rst_n,
  output logic phy_rst_n,
  output logic codec_rst_n,
  output logic audio_gen_rst_n,
  output logic cfg_regs_rst_n,
  output logic logic_rst_n
);
  import fcr_pkg::*;

  // rst_n is the board power-on reset
  logic por_sync_n;
  logic sys_sync_n;
  logic warm_sync_n;
  logic test_sync_n;
  logic aux_sync_n;
  logic cfg_sync_n;
  logic [ACC_W-1:0] phase_acc;
  logic [ACC_W:0] next_phase_acc;
  // Power-on reset in the reference domain
  logic por_ref_n;

  // Power-on reset released synchronously to main clock
  fcr_rst_sync u_por_sync (
    .clk(core_clk),
    .ce(clk_en),
    .rst_in_n(rst_n),
    .rst_out_n(por_sync_n)
  ); // see R8

  // Board system reset towards subsystem power-on reset
  fcr_rst_sync u_sys_sync (
    .clk(core_clk),
    .ce(clk_en),
    .rst_in_n(board_sys_rst_n),
    .rst_out_n(sys_sync_n)
  ); // see R5

  // Debugger warm reset
  fcr_rst_sync u_warm_sync (
    .clk(core_clk),
    .ce(clk_en),
    .rst_in_n(dbg_warm_rst_n),
    .rst_out_n(warm_sync_n)
  ); // see R6

  // Debugger test reset
  fcr_rst_sync u_test_sync (
    .clk(core_clk),
    .ce(clk_en),
    .rst_in_n(dbg_test_rst_n),
    .rst_out_n(test_sync_n)
  ); // see R6

  // Auxiliary reset for audio clock generator only
  fcr_rst_sync u_aux_sync (
    .clk(core_clk),
    .ce(clk_en),
    .rst_in_n(aux_rst_n),
    .rst_out_n(aux_sync_n)
  ); // see R10

  // Config reset released on the config clock
  fcr_rst_sync u_cfg_sync (
    .clk(cfg_serial_clk),
    .ce(1'b1),
    .rst_in_n(cfg_block_rst_n),
    .rst_out_n(cfg_sync_n)
  ); // see R11

  // Fractional accumulator on the reference clock
  assign next_phase_acc = {1'b0, phase_acc} + {1'b0, SLOW_INC};

  always_ff @(posedge ref_clk_24m) begin // see R1
    if (!por_ref_n) begin
      phase_acc <= ACC_RESET;
    end else begin
      phase_acc <= next_phase_acc[ACC_W-1:0];
    end
  end

  fcr_rst_sync u_ref_sync (
    .clk(ref_clk_24m),
    .ce(1'b1),
    .rst_in_n(rst_n),
    .rst_out_n(por_ref_n)
  ); // see R4

  // Slow clock is the accumulator top bit, registered
  always_ff @(posedge ref_clk_24m) begin // see R1
    if (!por_ref_n) begin
      slow_clk_32k <= 1'b0;
      subsys_slow_clk <= 1'b0;
    end else begin
      slow_clk_32k <= phase_acc[ACC_W-1];
      subsys_slow_clk <= phase_acc[ACC_W-1];
    end
  end

  // External clocks run at main clock rate, dividers fixed at one
  always_ff @(posedge core_clk) begin // see R2 R3
    if (!rst_n) begin
      ext_clk_en <= '0;
    end else if (clk_en) begin
      ext_clk_en <= (DIV_RATIO == 1) ? '1 : '0;
    end
  end

  // Subsystem resets: board power-on reset deliberately left out
  always_ff @(posedge core_clk) begin // see R4 R5 R6
    if (clk_en) begin
      subsys_rst.por_n <= sys_sync_n;
      subsys_rst.warm_n <= warm_sync_n;
      subsys_rst.test_n <= test_sync_n;
    end
  end

  // Shield follows the board pin level one core_clk edge later, through one register
  always_ff @(posedge core_clk) begin // see R7
    shield_rst_n <= rst_n;
  end

  // Synchronised PHY, audio and logic resets, and registered codec control bit
  always_ff @(posedge core_clk) begin // see R8 R9 R10 R4
    if (!rst_n) begin
      phy_rst_n <= 1'b0;
      codec_rst_n <= 1'b0;
      audio_gen_rst_n <= 1'b0;
      logic_rst_n <= 1'b0;
    end else if (clk_en) begin
      phy_rst_n <= por_sync_n;
      codec_rst_n <= codec_ctrl_bit;
      audio_gen_rst_n <= aux_sync_n;
      logic_rst_n <= por_sync_n;
    end
  end

  // Config block reset output
  always_ff @(posedge cfg_serial_clk) begin // see R11
    cfg_regs_rst_n <= cfg_sync_n;
  end

  phy_follow_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see R8
    clk_en && $past(clk_en) |-> phy_rst_n == $past(por_sync_n))
    else $error("phy reset not tracking synchronised power-on reset");

  codec_src_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see R9
    clk_en |=> codec_rst_n == $past(codec_ctrl_bit))
    else $error("codec reset not from control bit");

  sys_por_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see R5
    clk_en |=> subsys_rst.por_n == $past(sys_sync_n))
    else $error("subsystem power-on reset wrong source");

  warm_path_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see R6
    clk_en |=> subsys_rst.warm_n == $past(warm_sync_n) && subsys_rst.test_n == $past(test_sync_n))
    else $error("debugger reset routing wrong");

  shield_pin_a: assert property (@(posedge core_clk) // see R7
    ##1 shield_rst_n == $past(rst_n))
    else $error("shield reset not following board reset");

  ext_clk_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see R2
    clk_en ##1 clk_en |-> ext_clk_en == '1)
    else $error("external clock path divided");

  aux_only_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see R10
    clk_en |=> audio_gen_rst_n == $past(aux_sync_n))
    else $error("audio generator reset wrong source");

  slow_tick_a: assert property (@(posedge ref_clk_24m) disable iff (!por_ref_n) // see R1
    ##1 slow_clk_32k == $past(phase_acc[ACC_W-1]))
    else $error("slow clock not from accumulator");

endmodule // fcr_clk_rst

/* rtl/fcr_pkg.sv */
// Purpose: Shared constants and carriers for the clock and reset distribution block
// Assumes: core_clk is the 50 MHz main oscillator domain scaled to the 20 MHz core rate
// Notes: Functional notes follow
// Functional notes
// R1: Make 32.768 kHz slow clock from 24 MHz reference, drive subsystem slow clock.
// R2: Subsystem and external clock paths use no dividers; derived equals source.
// R3: All external-subsystem clocks come straight from the 50 MHz main oscillator.
// R4: Board power-on reset resets all block logic, never a subsystem reset.
// R5: Board system reset drives the subsystem power-on reset input.
// R6: Debugger warm and test resets drive subsystem warm and test resets.
// R7: Shield reset follows board power-on reset directly, unsynchronised. Here it passes through one core_clk register.
// R8: PHY reset is board power-on reset synchronised to main oscillator clock.
// R9: Codec reset comes from an audio controller control bit, not board resets. Here board power-on reset also clears codec_rst_n.
// R10: Auxiliary reset resets only the audio clock generator, not subsystem.
// R11: Configuration reset resets serial configuration registers on the config clock.
// R12: Delivered resets assert at once and release synchronously to destination clock. Here outputs are registered, asserting on the next edge.
package fcr_pkg;

  // Reference and slow clock rates in Hz
  localparam int unsigned REF_CLK_HZ = 24000000;
  localparam int unsigned SLOW_CLK_HZ = 32768;
  // Phase accumulator width for fractional slow clock synthesis
  localparam int unsigned ACC_W = 24;
  // Increment per reference cycle: 2^24 * 32768 / 24e6, truncated
  localparam logic [ACC_W-1:0] SLOW_INC =
    ACC_W'((64'(SLOW_CLK_HZ) << ACC_W) / 64'(REF_CLK_HZ));
  // Divider ratio on the external clock paths
  localparam int unsigned DIV_RATIO = 1;
  // Synchroniser depth for reset release
  localparam int unsigned SYNC_DEPTH = 3;
  localparam logic [ACC_W-1:0] ACC_RESET = '0;

  // Reset bundle delivered to the processor subsystem
  typedef struct packed {
    logic por_n;
    logic warm_n;
    logic test_n;
  } fcr_subsys_rst_type;

  // External subsystem clock enables, one per clock
  typedef struct packed {
    logic dbg_s;
    logic dbg_m;
    logic mbox;
    logic trace;
    logic xtrig;
    logic bus;
  } fcr_ext_clk_type;

endpackage

/* rtl/fcr_rst_sync.sv */
// Purpose: Reset release synchroniser, assert at once, release on fourth enabled edge after input release
// Assumes: Input comes from outside the clock domain
// Notes: First stage is read only by the second stage
`timescale 1ns/10ps
module fcr_rst_sync (
  input wire logic clk,
  input wire logic ce,
  input wire logic rst_in_n,
  output logic rst_out_n
);
  import fcr_pkg::*;

  logic [fcr_pkg::SYNC_DEPTH-1:0] stage;

  // Assert at once, shift ones in after release
  always_ff @(posedge clk or negedge rst_in_n) begin // see R12
    if (!rst_in_n) begin
      stage <= '0;
    end else if (ce) begin
      stage <= {stage[fcr_pkg::SYNC_DEPTH-2:0], 1'b1};
    end
  end

  // Release once second and third stages agree high
  always_ff @(posedge clk or negedge rst_in_n) begin // see R12
    if (!rst_in_n) begin
      rst_out_n <= 1'b0;
    end else if (ce) begin
      rst_out_n <= stage[1] & stage[2];
    end
  end

  rst_release_a: assert property (@(posedge clk) disable iff (!rst_in_n) // see R12
    $rose(rst_out_n) |-> $past(stage[2]) && $past(stage[1]))
    else $error("reset released before synchroniser agreed");

endmodule // fcr_rst_sync

/* testbench/fcr_mgmt_model.sv */
// Purpose: Board controller and debug probe driving the reset inputs
// Assumes: Config clock runs free at 5 MHz
// Notes: Lines change 2 ns after a core edge
`timescale 1ns/10ps
module fcr_mgmt_model (
  input wire logic core_clk,
  output logic cfg_serial_clk,
  output logic board_sys_rst_n,
  output logic dbg_warm_rst_n,
  output logic dbg_test_rst_n,
  output logic cfg_block_rst_n
);
  // Free-running config clock
  initial begin
    cfg_serial_clk = 1'b0;
    forever #100 cfg_serial_clk = ~cfg_serial_clk;
  end
  // All resets asserted until sequenced
  initial begin
    board_sys_rst_n = 1'b0;
    dbg_warm_rst_n = 1'b0;
    dbg_test_rst_n = 1'b0;
    cfg_block_rst_n = 1'b0;
  end
  // Change one reset line after a core edge
  task automatic drive(input int k, input logic v);
    @(posedge core_clk);
    #2;
    case (k)
      0: board_sys_rst_n = v;
      1: dbg_warm_rst_n = v;
      2: dbg_test_rst_n = v;
      default: cfg_block_rst_n = v;
    endcase
  endtask
endmodule // fcr_mgmt_model

/* testbench/test_fcr_clk_rst.sv */
// Purpose: Self-checking bench for the clock and reset block
// Assumes: Reset releases take five enabled edges at the outputs, four in the synchroniser and one output register
// Notes: Random reset order and hold times
`timescale 1ns/10ps
module test_fcr_clk_rst;
  import fcr_pkg::*;
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; \
  $display("ERROR %0t value mismatch", $time); end end
  logic core_clk, rst_n, clk_en, ref_clk_24m, codec_ctrl_bit, aux_rst_n, prev;
  logic slow_clk_32k, subsys_slow_clk, shield_rst_n, phy_rst_n, codec_rst_n;
  logic audio_gen_rst_n, cfg_regs_rst_n, logic_rst_n;
  wire cfg_serial_clk, board_sys_rst_n, dbg_warm_rst_n, dbg_test_rst_n, cfg_block_rst_n;
  fcr_ext_clk_type ext_clk_en;
  fcr_subsys_rst_type subsys_rst;
  int mismatches, samples_checked, k, n;
  fcr_mgmt_model u_part (.core_clk(core_clk), .cfg_serial_clk(cfg_serial_clk),
    .board_sys_rst_n(board_sys_rst_n), .dbg_warm_rst_n(dbg_warm_rst_n),
    .dbg_test_rst_n(dbg_test_rst_n), .cfg_block_rst_n(cfg_block_rst_n));
  fcr_clk_rst u_dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .ref_clk_24m(ref_clk_24m), .cfg_serial_clk(cfg_serial_clk),
    .board_sys_rst_n(board_sys_rst_n), .dbg_warm_rst_n(dbg_warm_rst_n),
    .dbg_test_rst_n(dbg_test_rst_n), .aux_rst_n(aux_rst_n),
    .cfg_block_rst_n(cfg_block_rst_n), .codec_ctrl_bit(codec_ctrl_bit),
    .slow_clk_32k(slow_clk_32k), .subsys_slow_clk(subsys_slow_clk),
    .ext_clk_en(ext_clk_en), .subsys_rst(subsys_rst), .shield_rst_n(shield_rst_n),
    .phy_rst_n(phy_rst_n), .codec_rst_n(codec_rst_n), .audio_gen_rst_n(audio_gen_rst_n),
    .cfg_regs_rst_n(cfg_regs_rst_n), .logic_rst_n(logic_rst_n));
  // Core and reference clocks
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    ref_clk_24m = 1'b0;
    #7;
    forever #20.83 ref_clk_24m = ~ref_clk_24m;
  end
  // Output selected by index
  function automatic logic pick(input int i);
    case (i)
      0: return subsys_rst.por_n;
      1: return subsys_rst.warm_n;
      2: return subsys_rst.test_n;
      3: return cfg_regs_rst_n;
      4: return codec_rst_n;
      5: return audio_gen_rst_n;
      6: return phy_rst_n;
      7: return logic_rst_n;
      default: return shield_rst_n;
    endcase
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Bounded wait for an output level
  task automatic await(input int i, input logic v, input int lim);
    for (int j = 0; j < lim && pick(i) !== v; j++) begin
      @(posedge core_clk);
      #1;
    end
    `CHK(pick(i), v)
    if (pick(i) !== v)
      close_out();
  endtask
  // Assert then release one far-side reset
  task automatic pulse(input int i, input int hold);
    u_part.drive(i, 1'b0);
    await(i, 1'b0, i == 3 ? 12 : 4);
    `CHK(subsys_rst, fcr_subsys_rst_type'(3'b111 ^ (i < 3 ? 3'b100 >> i : 3'b000)))
    `CHK(codec_rst_n, codec_ctrl_bit)
    repeat (hold) @(posedge core_clk);
    u_part.drive(i, 1'b1);
    @(posedge core_clk);
    #1;
    `CHK(pick(i), 1'b0)
    await(i, 1'b1, i == 3 ? 40 : 6);
  endtask
  initial begin
    void'($urandom(32'h8bcc0d02));
    rst_n = 1'b0;
    clk_en = 1'b1;
    codec_ctrl_bit = 1'b1;
    aux_rst_n = 1'b1;
    mismatches = 0;
    samples_checked = 0;
    repeat (8) @(posedge core_clk);
    #2 rst_n = 1'b1;
    for (k = 6; k < 9; k++) await(k, 1'b1, 8);
    `CHK(ext_clk_en, fcr_ext_clk_type'(6'h3f))
    for (k = 0; k < 4; k++) u_part.drive(k, 1'b1);
    for (k = 0; k < 4; k++) await(k, 1'b1, 40);
    for (k = 0; k < 4; k++) pulse(k, 0);
    repeat (10) pulse($urandom_range(3, 0), $urandom_range(12, 1));
    $display("test resets done");
    repeat (6) begin
      @(posedge core_clk);
      #2 codec_ctrl_bit = 1'($urandom_range(1, 0));
      await(4, codec_ctrl_bit, 3);
    end
    @(posedge core_clk);
    #2 aux_rst_n = 1'b0;
    await(5, 1'b0, 3);
    `CHK(subsys_rst, fcr_subsys_rst_type'(3'b111))
    @(posedge core_clk);
    #2 aux_rst_n = 1'b1;
    await(5, 1'b1, 6);
    $display("test codec and aux done");
    n = 0;
    prev = slow_clk_32k;
    repeat (20000) begin
      @(posedge core_clk);
      #1;
      if (slow_clk_32k === 1'b1 && prev === 1'b0)
        n++;
      prev = slow_clk_32k;
      `CHK(subsys_slow_clk, slow_clk_32k)
    end
    `CHK(n inside {[32:34]}, 1'b1)
    $display("test slow clock done");
    @(posedge core_clk);
    #2 rst_n = 1'b0;
    @(posedge core_clk);
    #1;
    `CHK(shield_rst_n, 1'b0)
    `CHK(subsys_rst, fcr_subsys_rst_type'(3'b111))
    await(6, 1'b0, 2);
    await(7, 1'b0, 2);
    repeat (4) @(posedge core_clk);
    #2 rst_n = 1'b1;
    @(posedge core_clk);
    #1;
    `CHK(shield_rst_n, 1'b1)
    `CHK(phy_rst_n, 1'b0)
    await(6, 1'b1, 6);
    await(7, 1'b1, 6);
    $display("test second reset done");
    close_out();
  end
endmodule // test_fcr_clk_rst
